// ==== logic/pmc_pkg.sv ====
package pmc_pkg;

    // Register offsets on the I2C map
    localparam logic [7:0] PWR_CTRL_OFS  = 8'h1B;
    localparam logic [7:0] DDR_REF_OFS   = 8'h6A;
    localparam logic [7:0] STATUS_OFS    = 8'h7E;
    localparam logic [7:0] ON_SET_BASE   = 8'h20;
    localparam logic [7:0] STBY_SET_BASE = 8'h30;

    // Field positions
    localparam int STBY_INV_BIT = 6;
    localparam int DDR_EN_BIT   = 4;
    localparam int REG_EN_BIT   = 7;

    // Values after reset, the unmapped read value and the default I2C address
    localparam logic [7:0] PWR_CTRL_RST = 8'h10;
    localparam logic [7:0] DDR_REF_RST  = 8'h00;
    localparam logic [7:0] ON_SET_RST   = 8'h80;
    localparam logic [7:0] UNMAPPED_RD  = 8'h00;
    localparam logic [6:0] I2C_ADDR_DEF = 7'h08;

    // Bit counts within one I2C byte slot
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] ACK_BIT   = 4'h9;

    // Operating states
    typedef enum logic [4:0] {
        ST_OFF     = 5'h01,
        ST_COIN    = 5'h02,
        ST_SLEEP   = 5'h04,
        ST_STANDBY = 5'h08,
        ST_ON      = 5'h10
    } pmc_state_e;

    // I2C target phases
    typedef enum logic [4:0] {
        I2_IDLE = 5'h01,
        I2_ADDR = 5'h02,
        I2_PTR  = 5'h04,
        I2_WDAT = 5'h08,
        I2_RDAT = 5'h10
    } pmc_i2c_e;

endpackage

// ==== logic/pmc_i2c_target.sv ====
module pmc_i2c_target (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // Configuration
    input  wire logic [6:0] devAddr,
    input  wire logic       accessEn,
    // I2C pins
    input  wire logic       sclPin,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe,
    // Register side
    output logic [7:0]      regAddr,
    output logic [7:0]      wrData,
    output logic            wrStb,
    input  wire logic [7:0] rdData
);

    logic             sclS1, sclS2, sclS3;
    logic             sdaS1, sdaS2, sdaS3;
    pmc_pkg::pmc_i2c_e phaseQ;
    logic [3:0]       cntQ;
    logic [7:0]       shiftQ;
    logic [7:0]       txQ;
    logic [7:0]       ptrQ;
    logic             nackQ;
    logic             sclRise, sclFall, startCond, stopCond;

    // Two-flop pin synchronisers, third stage only for edge detection
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            {sclS1, sclS2, sclS3} <= 3'h7;
            {sdaS1, sdaS2, sdaS3} <= 3'h7;
        end else begin
            {sclS1, sclS2, sclS3} <= {sclPin, sclS1, sclS2};
            {sdaS1, sdaS2, sdaS3} <= {sdaIn, sdaS1, sdaS2};
        end
    end

    // Bus conditions seen on synchronised levels
    assign sclRise   = sclS2 & ~sclS3;
    assign sclFall   = ~sclS2 & sclS3;
    assign startCond = sclS2 & sclS3 & sdaS3 & ~sdaS2;
    assign stopCond  = sclS2 & sclS3 & ~sdaS3 & sdaS2;

    // Data line is only ever pulled low, never driven high
    always_ff @(posedge clk) begin
        sdaOut <= 1'b0;
    end

    // Byte engine: sample on rising clock, drive on falling clock
    always_ff @(posedge clk) begin
        wrStb <= 1'b0;
        if (sys_rst) begin
            phaseQ <= pmc_pkg::I2_IDLE;
            cntQ   <= 4'h0;
            shiftQ <= 8'h00;
            txQ    <= 8'h00;
            ptrQ   <= 8'h00;
            nackQ  <= 1'b0;
            sdaOe  <= 1'b0;
        end else if (startCond) begin
            phaseQ <= pmc_pkg::I2_ADDR;
            cntQ   <= 4'h0;
            sdaOe  <= 1'b0;
        end else if (stopCond) begin
            phaseQ <= pmc_pkg::I2_IDLE;
            sdaOe  <= 1'b0;
        end else if (phaseQ != pmc_pkg::I2_IDLE && sclRise) begin
            cntQ <= cntQ + 4'h1;
            if (cntQ < pmc_pkg::BYTE_BITS) begin
                shiftQ <= {shiftQ[6:0], sdaS2};
            end else if (phaseQ == pmc_pkg::I2_RDAT) begin
                nackQ <= sdaS2;
                if (!sdaS2) begin
                    ptrQ <= ptrQ + 8'h01; // Next read byte fetched at the falling edge
                end
            end
        end else if (phaseQ != pmc_pkg::I2_IDLE && sclFall) begin
            if (cntQ == pmc_pkg::BYTE_BITS) begin
                // Acknowledge slot; a disabled target stays silent
                if (phaseQ == pmc_pkg::I2_RDAT) begin
                    sdaOe <= 1'b0;
                end else if (phaseQ == pmc_pkg::I2_ADDR) begin
                    sdaOe <= accessEn && (shiftQ[7:1] == devAddr);
                end else begin
                    sdaOe <= accessEn;
                    wrStb <= accessEn && (phaseQ == pmc_pkg::I2_WDAT);
                end
            end else if (cntQ == pmc_pkg::ACK_BIT) begin
                cntQ <= 4'h0;
                unique case (phaseQ)
                    pmc_pkg::I2_ADDR: begin
                        if (!sdaOe) begin
                            phaseQ <= pmc_pkg::I2_IDLE;
                        end else if (shiftQ[0]) begin
                            phaseQ <= pmc_pkg::I2_RDAT;
                            txQ    <= rdData;
                            sdaOe  <= ~rdData[7];
                        end else begin
                            phaseQ <= pmc_pkg::I2_PTR;
                            sdaOe  <= 1'b0;
                        end
                    end
                    pmc_pkg::I2_PTR: begin
                        phaseQ <= sdaOe ? pmc_pkg::I2_WDAT : pmc_pkg::I2_IDLE;
                        ptrQ   <= shiftQ;
                        sdaOe  <= 1'b0;
                    end
                    pmc_pkg::I2_WDAT: begin
                        phaseQ <= sdaOe ? pmc_pkg::I2_WDAT : pmc_pkg::I2_IDLE;
                        ptrQ   <= ptrQ + 8'h01;
                        sdaOe  <= 1'b0;
                    end
                    pmc_pkg::I2_RDAT: begin
                        if (nackQ) begin
                            phaseQ <= pmc_pkg::I2_IDLE;
                        end else begin
                            txQ   <= rdData;
                            sdaOe <= ~rdData[7];
                        end
                    end
                    pmc_pkg::I2_IDLE: begin
                        phaseQ <= pmc_pkg::I2_IDLE;
                    end
                endcase
            end else if (phaseQ == pmc_pkg::I2_RDAT) begin
                sdaOe <= ~txQ[3'h7 - cntQ[2:0]];
            end
        end
    end

    // Register side straight from flops
    assign regAddr = ptrQ;
    assign wrData  = shiftQ;

endmodule

// ==== logic/pmc_power_mode_control.sv ====
// Behaviour
// - DDR reference enable from 0x6A bit 4
// - Five states: ON, OFF, Sleep, Standby, Coin
// - Power up only with input above threshold
// - No register access in Coin Cell
// - Interrupt only in Sleep, Standby, ON
// - Qualified turn-on event enters ON
// - Host reset released throughout ON
// - Turn-off event enters OFF
// - Thermal shutdown forces OFF from ON, Standby and Sleep
// - OFF keeps only core and nonvolatile supplies
// - Only turn-on event leaves OFF for ON
// - Host reset low throughout OFF
// - Decoded standby request enters Standby
// - Standby released leaves Standby at once
// - First power-up copies ON settings to Standby
// - Standby control is pin XOR invert bit
// - Standby request only acts from ON
// - Invert bit is 0x1B bit 6
module pmc_power_mode_control #(
    parameter int         N_REG    = 4,
    parameter logic [6:0] DEV_ADDR = pmc_pkg::I2C_ADDR_DEF
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // I2C register port
    input  wire logic             sclPin,
    input  wire logic             sdaIn,
    output logic                  sdaOut,
    output logic                  sdaOe,
    // Asynchronous pins
    input  wire logic             vinAboveUvPin,
    input  wire logic             standbyPin,
    // Qualified events from on-chip logic
    input  wire logic             turnOnEvt,
    input  wire logic             turnOffEvt,
    input  wire logic             sleepEvt,
    input  wire logic             thermalShutdown,
    input  wire logic             faultPending,
    // Host-facing pins
    output logic                  hostResetOutN,
    output logic                  interruptOutN,
    // Supply enables
    output logic                  ddrRefOutputEnable,
    output logic                  digitalCoreSupplyEn,
    output logic                  secureNonvolatileSupplyEn,
    output logic [N_REG-1:0]      regEnable
);

    pmc_pkg::pmc_state_e stateQ, stateD;
    logic             vinS1, vinS2;
    logic             stbyS1, stbyS2;
    logic             stbyCtl;
    logic             vinOk;
    logic [7:0]       pwrCtrlQ;
    logic [7:0]       ddrRefQ;
    logic [7:0]       onSetQ   [N_REG];
    logic [7:0]       stbySetQ [N_REG];
    logic             firstUpQ;
    logic [7:0]       regAddr;
    logic [7:0]       wrData;
    logic             wrStb;
    logic [7:0]       rdData;
    logic             accessEn;
    logic             copyNow;

    // Hits a set-point bank; both banks share the same decode
    function automatic logic inBank(input logic [7:0] addr, input logic [7:0] base);
        inBank = (addr >= base) && ({24'h00_0000, addr} < ({24'h00_0000, base} + N_REG));
    endfunction

    // Offset of an address within a set-point bank
    function automatic int bankIdx(input logic [7:0] addr, input logic [7:0] base);
        bankIdx = int'(addr - base);
    endfunction

    // Pins from outside the clock domain pass two flops first
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            vinS1  <= 1'b0;
            vinS2  <= 1'b0;
            stbyS1 <= 1'b0;
            stbyS2 <= 1'b0;
        end else begin
            vinS1  <= vinAboveUvPin;
            vinS2  <= vinS1;
            stbyS1 <= standbyPin;
            stbyS2 <= stbyS1;
        end
    end

    assign vinOk   = vinS2;
    // Polarity decode on the synchronised level only
    assign stbyCtl = stbyS2 ^ pwrCtrlQ[pmc_pkg::STBY_INV_BIT];

    // Register port is dead while running from the coin cell
    assign accessEn = (stateQ != pmc_pkg::ST_COIN);

    pmc_i2c_target u_i2c (
        .clk     (clk),
        .sys_rst (sys_rst),
        .devAddr (DEV_ADDR),
        .accessEn(accessEn),
        .sclPin  (sclPin),
        .sdaIn   (sdaIn),
        .sdaOut  (sdaOut),
        .sdaOe   (sdaOe),
        .regAddr (regAddr),
        .wrData  (wrData),
        .wrStb   (wrStb),
        .rdData  (rdData)
    );

    // Next operating state; loss of input supply outranks everything
    always_comb begin
        stateD = stateQ;
        unique case (stateQ)
            pmc_pkg::ST_COIN: begin
                if (vinOk) begin
                    stateD = pmc_pkg::ST_OFF;
                end
            end
            pmc_pkg::ST_OFF: begin
                if (!vinOk) begin
                    stateD = pmc_pkg::ST_COIN;
                end else if (turnOnEvt && !thermalShutdown) begin
                    stateD = pmc_pkg::ST_ON;
                end
            end
            pmc_pkg::ST_SLEEP: begin
                if (!vinOk) begin
                    stateD = pmc_pkg::ST_COIN;
                end else if (thermalShutdown || turnOffEvt) begin
                    stateD = pmc_pkg::ST_OFF;
                end else if (turnOnEvt) begin
                    stateD = pmc_pkg::ST_ON;
                end
            end
            pmc_pkg::ST_STANDBY: begin
                if (!vinOk) begin
                    stateD = pmc_pkg::ST_COIN;
                end else if (thermalShutdown || turnOffEvt) begin
                    stateD = pmc_pkg::ST_OFF;
                end else if (sleepEvt) begin
                    stateD = pmc_pkg::ST_SLEEP;
                end else if (!stbyCtl) begin
                    stateD = pmc_pkg::ST_ON;
                end
            end
            pmc_pkg::ST_ON: begin
                if (!vinOk) begin
                    stateD = pmc_pkg::ST_COIN;
                end else if (thermalShutdown || turnOffEvt) begin
                    stateD = pmc_pkg::ST_OFF;
                end else if (sleepEvt) begin
                    stateD = pmc_pkg::ST_SLEEP;
                end else if (stbyCtl) begin
                    stateD = pmc_pkg::ST_STANDBY;
                end
            end
            default: begin
                stateD = pmc_pkg::ST_OFF;
            end
        endcase
    end

    // Start in Coin Cell until the input supply is seen valid
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stateQ <= pmc_pkg::ST_COIN;
        end else begin
            stateQ <= stateD;
        end
    end

    // First entry to ON mirrors ON settings into Standby settings
    assign copyNow = firstUpQ && (stateD == pmc_pkg::ST_ON) && (stateQ != pmc_pkg::ST_ON);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            firstUpQ <= 1'b1;
        end else if (copyNow) begin
            firstUpQ <= 1'b0;
        end
    end

    // Control registers; unused bits of the DDR register never store
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pwrCtrlQ <= pmc_pkg::PWR_CTRL_RST;
            ddrRefQ  <= pmc_pkg::DDR_REF_RST;
        end else if (wrStb && accessEn) begin
            if (regAddr == pmc_pkg::PWR_CTRL_OFS) begin
                pwrCtrlQ <= wrData;
            end
            if (regAddr == pmc_pkg::DDR_REF_OFS) begin
                ddrRefQ <= wrData & (8'h01 << pmc_pkg::DDR_EN_BIT);
            end
        end
    end

    // Set-point banks; the one-time copy yields to nothing but reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < N_REG; i++) begin
                onSetQ[i]   <= pmc_pkg::ON_SET_RST;
                stbySetQ[i] <= pmc_pkg::ON_SET_RST;
            end
        end else begin
            if (wrStb && accessEn && inBank(regAddr, pmc_pkg::ON_SET_BASE)) begin
                onSetQ[bankIdx(regAddr, pmc_pkg::ON_SET_BASE)] <= wrData;
            end
            if (copyNow) begin
                for (int i = 0; i < N_REG; i++) begin
                    stbySetQ[i] <= onSetQ[i];
                end
            end else if (wrStb && accessEn && inBank(regAddr, pmc_pkg::STBY_SET_BASE)) begin
                stbySetQ[bankIdx(regAddr, pmc_pkg::STBY_SET_BASE)] <= wrData;
            end
        end
    end

    // Read mux; unmapped addresses read as zero
    always_comb begin
        rdData = pmc_pkg::UNMAPPED_RD;
        if (regAddr == pmc_pkg::PWR_CTRL_OFS) begin
            rdData = pwrCtrlQ;
        end else if (regAddr == pmc_pkg::DDR_REF_OFS) begin
            rdData = ddrRefQ;
        end else if (regAddr == pmc_pkg::STATUS_OFS) begin
            rdData = {3'h0, stateQ};
        end else if (inBank(regAddr, pmc_pkg::ON_SET_BASE)) begin
            rdData = onSetQ[bankIdx(regAddr, pmc_pkg::ON_SET_BASE)];
        end else if (inBank(regAddr, pmc_pkg::STBY_SET_BASE)) begin
            rdData = stbySetQ[bankIdx(regAddr, pmc_pkg::STBY_SET_BASE)];
        end
    end

    // Host reset: released only in ON, Standby and Sleep
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hostResetOutN <= 1'b0;
        end else begin
            hostResetOutN <= (stateD == pmc_pkg::ST_ON)
                          || (stateD == pmc_pkg::ST_STANDBY)
                          || (stateD == pmc_pkg::ST_SLEEP);
        end
    end

    // Interrupt line gated by operating state
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            interruptOutN <= 1'b1;
        end else begin
            interruptOutN <= !(faultPending && ((stateD == pmc_pkg::ST_ON)
                          || (stateD == pmc_pkg::ST_STANDBY) || (stateD == pmc_pkg::ST_SLEEP)));
        end
    end

    // DDR reference follows its enable bit in ON and Standby; off in OFF, Sleep and coin cell
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ddrRefOutputEnable <= 1'b0;
        end else begin
            ddrRefOutputEnable <= ddrRefQ[pmc_pkg::DDR_EN_BIT] && (stateD == pmc_pkg::ST_ON
                               || stateD == pmc_pkg::ST_STANDBY);
        end
    end

    // Always-on supplies stay up in every state
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            digitalCoreSupplyEn       <= 1'b1;
            secureNonvolatileSupplyEn <= 1'b1;
        end else begin
            digitalCoreSupplyEn       <= 1'b1;
            secureNonvolatileSupplyEn <= 1'b1;
        end
    end

    // Regulator enables from the bank that matches the state
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            regEnable <= '0;
        end else begin
            for (int i = 0; i < N_REG; i++) begin
                unique case (stateD)
                    pmc_pkg::ST_ON:      regEnable[i] <= onSetQ[i][pmc_pkg::REG_EN_BIT];
                    pmc_pkg::ST_STANDBY: regEnable[i] <= stbySetQ[i][pmc_pkg::REG_EN_BIT];
                    pmc_pkg::ST_OFF:     regEnable[i] <= 1'b0;
                    pmc_pkg::ST_SLEEP:   regEnable[i] <= 1'b0;
                    pmc_pkg::ST_COIN:    regEnable[i] <= 1'b0;
                endcase
            end
        end
    end

endmodule

// ==== tb/pmc_power_mode_control_monitor.sv ====
module pmc_checker #(
    parameter int N_REG = 4
) (
    // Clock and reset
    input wire logic             clk,
    input wire logic             sys_rst,
    // Inputs watched
    input wire logic             vinAboveUvPin,
    input wire logic             turnOnEvt,
    input wire logic             turnOffEvt,
    input wire logic             sleepEvt,
    input wire logic             thermalShutdown,
    input wire logic             faultPending,
    // Outputs watched
    input wire logic             hostResetOutN,
    input wire logic             interruptOutN,
    input wire logic             ddrRefOutputEnable,
    input wire logic             digitalCoreSupplyEn,
    input wire logic             secureNonvolatileSupplyEn,
    input wire logic [N_REG-1:0] regEnable
);
    timeunit 1ns;
    timeprecision 1ps;
    // One domain, so clock and disable are shared
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    // Reset output low means OFF or Coin Cell, the only way the host can tell
    thermal_off_a: assert property (thermalShutdown |=> !hostResetOutN && regEnable == '0 && interruptOutN)
        else $error("thermal shutdown did not force off");
    turn_off_a: assert property (turnOffEvt |=> !hostResetOutN)
        else $error("turn-off event did not reach off");
    off_supplies_a: assert property (!hostResetOutN |-> digitalCoreSupplyEn && secureNonvolatileSupplyEn
        && regEnable == '0) else $error("supplies wrong while reset is held");
    int_gate_a: assert property (!hostResetOutN |-> interruptOutN)
        else $error("interrupt active outside active states");
    int_follow_a: assert property (hostResetOutN |-> interruptOutN == !$past(faultPending))
        else $error("interrupt does not follow pending fault");
    // Six cycles of good supply rule out Coin Cell behind the synchronisers
    turn_on_a: assert property (vinAboveUvPin [*6] ##0 (turnOnEvt && !thermalShutdown && !turnOffEvt
        && !sleepEvt && !hostResetOutN) |=> hostResetOutN) else $error("turn-on event ignored in off");
    off_hold_a: assert property (!hostResetOutN && !turnOnEvt && !sleepEvt |=> !hostResetOutN)
        else $error("left off without a turn-on event");
    on_hold_a: assert property (vinAboveUvPin [*4] ##0 (hostResetOutN && !turnOffEvt && !thermalShutdown)
        |=> hostResetOutN) else $error("host reset dropped while powered");
    ddr_gate_a: assert property (ddrRefOutputEnable |-> hostResetOutN)
        else $error("reference enabled while off");

    // Main scenarios reached
    cover property (turnOnEvt ##1 hostResetOutN);
    cover property (thermalShutdown && hostResetOutN);
    cover property (hostResetOutN && !interruptOutN);
endmodule

bind pmc_power_mode_control pmc_checker #(.N_REG(N_REG)) pmc_checker_i (
    .clk(clk), .sys_rst(sys_rst), .vinAboveUvPin(vinAboveUvPin), .turnOnEvt(turnOnEvt),
    .turnOffEvt(turnOffEvt), .sleepEvt(sleepEvt), .thermalShutdown(thermalShutdown),
    .faultPending(faultPending), .hostResetOutN(hostResetOutN), .interruptOutN(interruptOutN),
    .ddrRefOutputEnable(ddrRefOutputEnable), .digitalCoreSupplyEn(digitalCoreSupplyEn),
    .secureNonvolatileSupplyEn(secureNonvolatileSupplyEn), .regEnable(regEnable)
);

// ==== tb/pmc_host_model.sv ====
module pmc_host_model #(
    parameter logic [6:0] DEV = 7'h08
) (
    // Clock
    input wire logic clk,
    // Device side
    input wire logic sdaOe,
    output logic     sclPin,
    output logic     sdaIn,
    output logic     standbyPin,
    // Bench control
    input wire logic standbyReq,
    input wire logic activeLow
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sdaDrv;

    // Open drain data line with pull-up
    assign sdaIn = sdaDrv & !sdaOe;
    // Host applies its own polarity, so the request reaches the pin inverted when active low
    assign standbyPin = standbyReq ^ activeLow;

    initial begin
        sclPin = 1'b1;
        sdaDrv = 1'b1;
    end

    // Ten cycles a phase, above the three the target needs to see an edge and answer
    task automatic halfBit;
        repeat (10) @(negedge clk);
    endtask

    task automatic bitx(input logic b, output logic s);
        @(negedge clk);
        sdaDrv = b;
        halfBit();
        sclPin = 1'b1;
        halfBit();
        s = sdaIn;
        sclPin = 1'b0;
    endtask

    task automatic startCond;
        @(negedge clk);
        sdaDrv = 1'b1;
        halfBit();
        sclPin = 1'b1;
        halfBit();
        sdaDrv = 1'b0;
        halfBit();
        sclPin = 1'b0;
    endtask

    task automatic stopCond;
        @(negedge clk);
        sdaDrv = 1'b0;
        halfBit();
        sclPin = 1'b1;
        halfBit();
        sdaDrv = 1'b1;
        halfBit();
    endtask

    // Sends d MSB first, returns what the line held, then whether the ninth bit was low
    task automatic xbyte(input logic [7:0] d, output logic [7:0] r, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], s);
            r[i] = s;
        end
        bitx(1'b1, s);
        ack = !s;
    endtask

    task automatic regWrite(input logic [7:0] a, input logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic       k1, k2, k3;
        startCond();
        xbyte({DEV, 1'b0}, r, k1);
        xbyte(a, r, k2);
        xbyte(d, r, k3);
        stopCond();
        ok = k1 & k2 & k3;
    endtask

    // Pointer write, repeated start, one byte read then no ack
    task automatic regRead(input logic [7:0] a, output logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic       k1, k2, k3, k4;
        startCond();
        xbyte({DEV, 1'b0}, r, k1);
        xbyte(a, r, k2);
        startCond();
        xbyte({DEV, 1'b1}, r, k3);
        xbyte(8'hFF, d, k4);
        stopCond();
        ok = k1 & k2 & k3;
    endtask
endmodule

// ==== tb/pmc_power_mode_control_tb.sv ====
module pmc_power_mode_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin n_fail++; \
        $display("[FAIL] %s exp %h got %h", nm, e, a); end end
    logic        clk, sys_rst, sclPin, sdaIn, sdaOut, sdaOe, vin, standbyPin, stbyReq, actLow;
    logic        turnOn, turnOff, sleep, therm, fault, rstN, intN, ddrEn, coreEn, snvsEn, ok;
    logic [3:0]  regEn;
    logic [7:0]  d;
    logic [31:0] lfsr;
    int          n_fail, n_compared, cyc;

    pmc_power_mode_control #(.N_REG(4)) pmc_power_mode_control_i (
        .clk(clk), .sys_rst(sys_rst), .sclPin(sclPin), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .vinAboveUvPin(vin), .standbyPin(standbyPin), .turnOnEvt(turnOn), .turnOffEvt(turnOff),
        .sleepEvt(sleep), .thermalShutdown(therm), .faultPending(fault), .hostResetOutN(rstN),
        .interruptOutN(intN), .ddrRefOutputEnable(ddrEn), .digitalCoreSupplyEn(coreEn),
        .secureNonvolatileSupplyEn(snvsEn), .regEnable(regEn));
    pmc_host_model pmc_host_model_i (.clk(clk), .sdaOe(sdaOe), .sclPin(sclPin), .sdaIn(sdaIn),
        .standbyPin(standbyPin), .standbyReq(stbyReq), .activeLow(actLow));

    // 8 ns clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Hang guard, well above the roughly 28k cycles of traffic
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            n_fail++;
            wrap_up();
        end
    end

    function automatic logic [31:0] nextRand(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // Status byte and regulator enables expected in ON or Standby
    function automatic logic [7:0] stExp(input logic stby);
        return stby ? {3'h0, pmc_pkg::ST_STANDBY} : {3'h0, pmc_pkg::ST_ON};
    endfunction

    function automatic logic [3:0] enExp(input logic stby);
        return stby ? 4'hE : 4'hF;
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic k;
        pmc_host_model_i.regWrite(a, v, k);
        `CHK("writeAck", 1'b1, k)
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] r;
        logic       k;
        pmc_host_model_i.regRead(a, r, k);
        `CHK("readAck", 1'b1, k)
        `CHK("readData", e, r)
    endtask

    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
        repeat (3) @(negedge clk);
    endtask

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Main sequence, inputs change on falling edges
    initial begin
        {sys_rst, vin, stbyReq, actLow, turnOn, turnOff, sleep, therm, fault} = 9'h100;
        lfsr = 32'ha7a6;
        repeat (10) @(negedge clk);
        sys_rst = 1'b0;
        pulse(turnOn);
        `CHK("coinRst", 1'b0, rstN)
        pmc_host_model_i.regWrite(pmc_pkg::DDR_REF_OFS, 8'h10, ok);
        `CHK("coinAck", 1'b0, ok)
        vin = 1'b1;
        repeat (6) @(negedge clk);
        rdChk(pmc_pkg::STATUS_OFS, {3'h0, pmc_pkg::ST_OFF});
        rdChk(pmc_pkg::DDR_REF_OFS, pmc_pkg::DDR_REF_RST);
        rdChk(pmc_pkg::PWR_CTRL_OFS, pmc_pkg::PWR_CTRL_RST);
        stbyReq = 1'b1;
        repeat (6) @(negedge clk);
        rdChk(pmc_pkg::STATUS_OFS, {3'h0, pmc_pkg::ST_OFF});
        stbyReq = 1'b0;
        turnOn = 1'b1;
        therm = 1'b1;
        pulse(sleep);
        {turnOn, therm} = 2'b00;
        `CHK("offHold", 1'b0, rstN)
        pulse(turnOn);
        `CHK("onRst", 1'b1, rstN)
        `CHK("onRegs", 4'hF, regEn)
        rdChk(pmc_pkg::STBY_SET_BASE + 8'h01, pmc_pkg::ON_SET_RST);
        for (int i = 0; i < 8; i++) begin
            lfsr = nextRand(lfsr);
            wr(pmc_pkg::DDR_REF_OFS, lfsr[7:0]);
            `CHK("ddrEn", lfsr[4], ddrEn)
            rdChk(pmc_pkg::DDR_REF_OFS, lfsr[7:0] & 8'h10);
            fault = lfsr[9];
            repeat (2) @(negedge clk);
            `CHK("intOn", !lfsr[9], intN)
        end
        // Every pin and polarity pairing; invert bit first, then Standby settings, then the pin
        for (int k = 0; k < 4; k++) begin
            wr(pmc_pkg::PWR_CTRL_OFS, 8'h10 | (8'(k[1]) << pmc_pkg::STBY_INV_BIT));
            wr(pmc_pkg::STBY_SET_BASE, 8'h00);
            actLow = k[1];
            stbyReq = k[0];
            repeat (6) @(negedge clk);
            rdChk(pmc_pkg::STATUS_OFS, stExp(k[0]));
            `CHK("stbyRegs", enExp(k[0]), regEn)
            `CHK("stbyRst", 1'b1, rstN)
        end
        stbyReq = 1'b0;
        repeat (6) @(negedge clk);
        `CHK("exitRegs", 4'hF, regEn)
        pulse(sleep);
        fault = 1'b1;
        repeat (2) @(negedge clk);
        rdChk(pmc_pkg::STATUS_OFS, {3'h0, pmc_pkg::ST_SLEEP});
        `CHK("intSleep", 1'b0, intN)
        pulse(turnOn);
        pulse(therm);
        `CHK("thermRst", 1'b0, rstN)
        `CHK("thermInt", 1'b1, intN)
        `CHK("thermDdr", 1'b0, ddrEn)
        pulse(turnOn);
        pulse(turnOff);
        rdChk(pmc_pkg::STATUS_OFS, {3'h0, pmc_pkg::ST_OFF});
        `CHK("offSupply", 4'b1100, {coreEn, snvsEn, |regEn, sdaOut})
        vin = 1'b0;
        repeat (6) @(negedge clk);
        pmc_host_model_i.regRead(pmc_pkg::STATUS_OFS, d, ok);
        `CHK("coinRead", 1'b0, ok)
        wrap_up();
    end
endmodule
